// ---- rtl/ofp_consts.vh ----
// Purpose: constants for the overclock frequency program control block
// Assumes: byte-wide configuration registers reached by byte index
// Notes: offsets are register byte indices of the serial host map
`ifndef OFP_CONSTS_VH
`define OFP_CONSTS_VH

// Register indices
`define OFP_IDX_PROC_N_LOW   8'h0B
`define OFP_IDX_PROC_M       8'h0C
`define OFP_IDX_PCIE_N_LOW   8'h0D
`define OFP_IDX_CTRL14       8'h0E
`define OFP_IDX_RESTORE_LOW  8'h0F
`define OFP_IDX_ENABLES      8'h10
`define OFP_IDX_SOFT_RATE    8'h11
`define OFP_IDX_WDOG_MODE    8'h12

// Control byte 14 fields
`define OFP_C14_PCIE_N8      7
`define OFP_C14_TAKEOVER     5
`define OFP_C14_GLIDE_OWNER  4
`define OFP_C14_RESTORE_N8   0
// Byte 12 fields
`define OFP_B12_PROC_N8      7
// Enables byte fields
`define OFP_EN_REF_B         7
`define OFP_EN_FS_SERIAL     6
`define OFP_EN_PCIE_RATE     5
`define OFP_EN_SATA_SPREAD   3
`define OFP_EN_PCIE_PROG     2
`define OFP_EN_PROC_PROG     1
`define OFP_EN_AUTO_RESTORE  0
// Watchdog mode byte fields
`define OFP_WM_RESET_ONLY    1
`define OFP_WM_FROM_RESTORE  0

// Reset values
`define OFP_RST_BYTE         8'h00
`define OFP_RST_ENABLES      8'hC0
`define OFP_RST_NINE         9'h000
`define OFP_RST_SEVEN        7'h00
`define OFP_RST_FOUR         4'h0

// Recovery actions
`define OFP_REC_NONE         2'h0
`define OFP_REC_AUTO         2'h1
`define OFP_REC_MANUAL       2'h2
`define OFP_REC_STRAP        2'h3

// Fixed PCIe divider and 167 MHz select code
`define OFP_PCIE_FIXED_M     7'h0F
`define OFP_PCIE_RATE_167    2'h2
`define OFP_PCIE_RATE_100    2'h0
`define OFP_PCIE_RATE_STRAP  2'h1

// Smooth-switch step: 1 MHz per 0.667 us at 50 MHz
`define OFP_GLIDE_STEP_NS    667
`define OFP_CLK_PERIOD_NS    20

`endif

// ---- rtl/ofp_glide_ramp.v ----
// Purpose: smooth-switch ramp that walks a nine-bit N one code at a time
// Assumes: one code step moves the owning PLL by under 1 MHz
// Notes: shared by both PLLs; the owner selects which target it follows
`timescale 1ns/1ps
`default_nettype none
`include "ofp_consts.vh"

module ofp_glide_ramp #(
  parameter STEP_CYCLES = `OFP_GLIDE_STEP_NS / `OFP_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  input wire clkEn,
  // Target and ramp output
  input wire [8:0] targetN,
  input wire snapNow,
  output reg [8:0] rampN_reg,
  output wire rampBusy
);

  // ==========================================
  // Step timer
  reg [15:0] stepCnt_reg;
  wire stepDue = (stepCnt_reg == 16'h0000);

  assign rampBusy = (rampN_reg != targetN);

  // One code per step interval, snap when asked
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rampN_reg <= `OFP_RST_NINE;
      stepCnt_reg <= 16'h0000;
    end else if (clkEn) begin
      if (snapNow) begin
        rampN_reg <= targetN;
        stepCnt_reg <= 16'h0000;
      end else if (rampBusy) begin
        if (stepDue) begin
          stepCnt_reg <= STEP_CYCLES[15:0] - 16'h0001;
          if (rampN_reg < targetN)
            rampN_reg <= rampN_reg + 9'h001;
          else
            rampN_reg <= rampN_reg - 9'h001;
        end else begin
          stepCnt_reg <= stepCnt_reg - 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ofp_freq_control.v ----
// Purpose: frequency programming and recovery control of a clock synthesizer
// Assumes: byte writes arrive from the serial host engine, synchronous
// Notes: staged writes apply together when the write transaction ends
`timescale 1ns/1ps
`default_nettype none
`include "ofp_consts.vh"

module ofp_freq_control #(
  parameter STEP_CYCLES = `OFP_GLIDE_STEP_NS / `OFP_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire clkEn,
  // Register port from the serial engine
  input wire regWrite,
  input wire [7:0] regIndex,
  input wire [7:0] regWrData,
  input wire writeDone,
  output reg [7:0] regRdData,
  // Strap pins and watchdog
  input wire strapLatch,
  input wire [4:0] ratePins,
  input wire watchdogEnable,
  input wire watchdogTimeout,
  // Processor PLL settings
  output reg [8:0] procN,
  output reg [6:0] procM,
  output reg [4:0] procGearCode,
  output reg procProgActive,
  // PCIe PLL settings
  output reg [8:0] pcieN,
  output reg [6:0] pcieM,
  output reg [1:0] pcieRateSel,
  output reg pcieProgActive,
  // Feature outputs
  output reg sataSpreadOn,
  output reg refClkBOutEn,
  output reg fsSerialClkOutEn,
  output reg glideToPcie,
  output wire glideBusy,
  output reg [1:0] recoveryAction
);

  // ==========================================
  // Live registers as software sees them
  reg [8:0] procNLive_reg;
  reg [6:0] procMLive_reg;
  reg [8:0] pcieNLive_reg;
  reg [7:0] ctrl14_reg;
  reg [7:0] restoreLow_reg;
  reg [7:0] enables_reg;
  reg [3:0] softRate_reg;
  reg [1:0] wdogMode_reg;
  reg [4:0] strapCode_reg;
  reg [8:0] autoN_reg;
  reg [6:0] autoM_reg;
  reg [6:0] manualM_reg;
  reg wdogEnPrev_reg;

  // Applied copies, loaded when a write transaction ends or one cycle after a watchdog recovery
  reg [8:0] procNApp_reg;
  reg [6:0] procMApp_reg;
  reg [8:0] pcieNApp_reg;
  reg [7:0] enApp_reg;
  reg [7:0] c14App_reg;
  reg [3:0] softApp_reg;
  reg dirty_reg;
  reg recovering_reg;

  wire [8:0] restoreN = {ctrl14_reg[`OFP_C14_RESTORE_N8], restoreLow_reg};
  wire autoMode = enables_reg[`OFP_EN_AUTO_RESTORE];
  wire wdogRise = watchdogEnable & ~wdogEnPrev_reg;

  // Selects the recovery action from the mode bits
  function [1:0] pickAction;
    input resetOnly;
    input fromRestore;
    input autoOn;
    begin
      if (resetOnly)
        pickAction = `OFP_REC_NONE;
      else if (!fromRestore)
        pickAction = `OFP_REC_STRAP;
      else if (autoOn)
        pickAction = `OFP_REC_AUTO;
      else
        pickAction = `OFP_REC_MANUAL;
    end
  endfunction

  // Current recovery choice
  always @* begin
    recoveryAction = pickAction(wdogMode_reg[`OFP_WM_RESET_ONLY],
      wdogMode_reg[`OFP_WM_FROM_RESTORE], autoMode);
  end

  // ==========================================
  // Register writes, strap latch and watchdog recovery
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      procNLive_reg <= `OFP_RST_NINE;
      procMLive_reg <= `OFP_RST_SEVEN;
      pcieNLive_reg <= `OFP_RST_NINE;
      ctrl14_reg <= `OFP_RST_BYTE;
      restoreLow_reg <= `OFP_RST_BYTE;
      enables_reg <= `OFP_RST_ENABLES;
      softRate_reg <= `OFP_RST_FOUR;
      wdogMode_reg <= 2'h0;
      strapCode_reg <= 5'h00;
      autoN_reg <= `OFP_RST_NINE;
      autoM_reg <= `OFP_RST_SEVEN;
      manualM_reg <= `OFP_RST_SEVEN;
      wdogEnPrev_reg <= 1'b0;
      dirty_reg <= 1'b0;
      recovering_reg <= 1'b0;
    end else if (clkEn) begin
      wdogEnPrev_reg <= watchdogEnable;
      recovering_reg <= 1'b0;
      if (strapLatch)
        strapCode_reg <= ratePins;
      // Capture settings for recovery at watchdog enable
      if (wdogRise) begin
        autoM_reg <= procMLive_reg;
        manualM_reg <= procMLive_reg;
        autoN_reg <= procNLive_reg;
        if (autoMode) begin
          restoreLow_reg <= procNLive_reg[7:0];
          ctrl14_reg[`OFP_C14_RESTORE_N8] <= procNLive_reg[8];
        end
      end
      if (regWrite) begin
        dirty_reg <= 1'b1;
        if (regIndex == `OFP_IDX_PROC_N_LOW) begin
          procNLive_reg[7:0] <= regWrData;
        end else if (regIndex == `OFP_IDX_PROC_M) begin
          procNLive_reg[8] <= regWrData[`OFP_B12_PROC_N8];
          procMLive_reg <= regWrData[6:0];
        end else if (regIndex == `OFP_IDX_PCIE_N_LOW) begin
          pcieNLive_reg[7:0] <= regWrData;
        end else if (regIndex == `OFP_IDX_CTRL14) begin
          pcieNLive_reg[8] <= regWrData[`OFP_C14_PCIE_N8];
          ctrl14_reg[`OFP_C14_TAKEOVER] <= regWrData[`OFP_C14_TAKEOVER];
          ctrl14_reg[`OFP_C14_GLIDE_OWNER] <=
            regWrData[`OFP_C14_GLIDE_OWNER];
          if (!autoMode)
            ctrl14_reg[`OFP_C14_RESTORE_N8] <=
              regWrData[`OFP_C14_RESTORE_N8];
        end else if (regIndex == `OFP_IDX_RESTORE_LOW) begin
          if (!autoMode)
            restoreLow_reg <= regWrData;
        end else if (regIndex == `OFP_IDX_ENABLES) begin
          enables_reg <= regWrData & 8'hEF;
        end else if (regIndex == `OFP_IDX_SOFT_RATE) begin
          softRate_reg <= regWrData[3:0];
        end else if (regIndex == `OFP_IDX_WDOG_MODE) begin
          wdogMode_reg <= regWrData[1:0];
        end
      end else if (writeDone) begin
        dirty_reg <= 1'b0;
      end
      // Timeout during processor programmed mode restores settings, except in reset-only mode
      if (watchdogTimeout && enApp_reg[`OFP_EN_PROC_PROG]) begin
        recovering_reg <= 1'b1;
        case (recoveryAction)
          `OFP_REC_AUTO: begin
            procNLive_reg <= autoN_reg;
            procMLive_reg <= autoM_reg;
          end
          `OFP_REC_MANUAL: begin
            procNLive_reg <= restoreN;
            procMLive_reg <= manualM_reg;
          end
          `OFP_REC_STRAP: begin
            enables_reg[`OFP_EN_PROC_PROG] <= 1'b0;
            ctrl14_reg[`OFP_C14_TAKEOVER] <= 1'b0;
          end
          default: begin
            recovering_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Apply staged values at the end of the write
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      procNApp_reg <= `OFP_RST_NINE;
      procMApp_reg <= `OFP_RST_SEVEN;
      pcieNApp_reg <= `OFP_RST_NINE;
      enApp_reg <= `OFP_RST_ENABLES;
      c14App_reg <= `OFP_RST_BYTE;
      softApp_reg <= `OFP_RST_FOUR;
    end else if (clkEn) begin
      if ((writeDone && dirty_reg && !regWrite) || recovering_reg) begin
        procNApp_reg <= procNLive_reg;
        procMApp_reg <= procMLive_reg;
        pcieNApp_reg <= pcieNLive_reg;
        enApp_reg <= enables_reg;
        c14App_reg <= ctrl14_reg;
        softApp_reg <= softRate_reg;
      end
    end
  end

  // ==========================================
  // Shared glide circuit
  wire ownerPcie = c14App_reg[`OFP_C14_GLIDE_OWNER];
  wire [8:0] glideTarget = ownerPcie ? pcieNApp_reg : procNApp_reg;
  wire [8:0] glideN;
  reg ownerPrev_reg;

  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      ownerPrev_reg <= 1'b0;
    else if (clkEn)
      ownerPrev_reg <= ownerPcie;
  end

  ofp_glide_ramp #(
    .STEP_CYCLES(STEP_CYCLES)
  ) uGlide (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .targetN(glideTarget),
    .snapNow(ownerPcie != ownerPrev_reg),
    .rampN_reg(glideN),
    .rampBusy(glideBusy)
  );

  // ==========================================
  // PLL setting outputs
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      procN <= `OFP_RST_NINE;
      procM <= `OFP_RST_SEVEN;
      procGearCode <= 5'h00;
      procProgActive <= 1'b0;
      pcieN <= `OFP_RST_NINE;
      pcieM <= `OFP_PCIE_FIXED_M;
      pcieRateSel <= `OFP_PCIE_RATE_100;
      pcieProgActive <= 1'b0;
      sataSpreadOn <= 1'b0;
      refClkBOutEn <= 1'b1;
      fsSerialClkOutEn <= 1'b1;
      glideToPcie <= 1'b0;
    end else if (clkEn) begin
      procProgActive <= enApp_reg[`OFP_EN_PROC_PROG];
      // Both PLLs take applied N in the handover cycle while the ramp snaps
      procN <= (ownerPcie || ownerPrev_reg) ? procNApp_reg : glideN;
      procM <= procMApp_reg;
      // Gear code from latched strap or soft choice
      if (c14App_reg[`OFP_C14_TAKEOVER])
        procGearCode <= {1'b0, softApp_reg};
      else
        procGearCode <= strapCode_reg;
      pcieProgActive <= enApp_reg[`OFP_EN_PCIE_PROG];
      pcieN <= (ownerPcie && ownerPrev_reg) ? glideN : pcieNApp_reg;
      pcieM <= `OFP_PCIE_FIXED_M;
      if (enApp_reg[`OFP_EN_PCIE_RATE])
        pcieRateSel <= `OFP_PCIE_RATE_167;
      else if (strapCode_reg[4])
        pcieRateSel <= `OFP_PCIE_RATE_STRAP;
      else
        pcieRateSel <= `OFP_PCIE_RATE_100;
      sataSpreadOn <= enApp_reg[`OFP_EN_SATA_SPREAD];
      refClkBOutEn <= enApp_reg[`OFP_EN_REF_B];
      fsSerialClkOutEn <= enApp_reg[`OFP_EN_FS_SERIAL];
      glideToPcie <= ownerPcie;
    end
  end

  // ==========================================
  // Read back, registered
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= `OFP_RST_BYTE;
    end else if (clkEn) begin
      if (regIndex == `OFP_IDX_PROC_N_LOW)
        regRdData <= procNLive_reg[7:0];
      else if (regIndex == `OFP_IDX_PROC_M)
        regRdData <= {procNLive_reg[8], procMLive_reg};
      else if (regIndex == `OFP_IDX_PCIE_N_LOW)
        regRdData <= pcieNLive_reg[7:0];
      else if (regIndex == `OFP_IDX_CTRL14)
        regRdData <= {pcieNLive_reg[8], 1'b0, ctrl14_reg[5:4], 3'b000,
          ctrl14_reg[0]};
      else if (regIndex == `OFP_IDX_RESTORE_LOW)
        regRdData <= restoreLow_reg;
      else if (regIndex == `OFP_IDX_ENABLES)
        regRdData <= enables_reg;
      else if (regIndex == `OFP_IDX_SOFT_RATE)
        regRdData <= {4'h0, softRate_reg};
      else if (regIndex == `OFP_IDX_WDOG_MODE)
        regRdData <= {6'h00, wdogMode_reg};
      else
        regRdData <= `OFP_RST_BYTE;
    end
  end

endmodule
`default_nettype wire

// ---- sim/ofp_freq_properties.sv ----
// Purpose: port checker for the frequency program control block
// Assumes: staged values reach the outputs two edges after writeDone
// Notes: attached to the design top by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module ofp_freq_properties #(
  parameter STEP_CYCLES = 2
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Control inputs
  input wire writeDone,
  input wire watchdogEnable,
  input wire watchdogTimeout,
  // Observed outputs
  input wire [8:0] procN,
  input wire [6:0] procM,
  input wire procProgActive,
  input wire [8:0] pcieN,
  input wire [6:0] pcieM,
  input wire sataSpreadOn,
  input wire refClkBOutEn,
  input wire fsSerialClkOutEn,
  input wire glideToPcie,
  input wire glideBusy,
  input wire [1:0] recoveryAction
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Steps: stop seen, timeout seen, strap case
  sequence done_seen_s;
    $past(writeDone, 2);
  endsequence
  sequence timeout_seen_s;
    $past(watchdogTimeout, 3);
  endsequence
  sequence strap_timeout_s;
    watchdogTimeout && watchdogEnable && procProgActive
      && recoveryAction == 2'h3;
  endsequence
  // ==========================================
  // Properties
  reset_outs_a: assert property (
    $fell(rst) |-> refClkBOutEn && fsSerialClkOutEn && !sataSpreadOn
      && !procProgActive && procN == 9'h000 && procM == 7'h00)
    else $error("outputs wrong after reset");
  pcie_div_fixed_a: assert property (pcieM == 7'h0F)
    else $error("pcie divider not fixed");
  prog_apply_a: assert property (
    $changed(procProgActive) |-> done_seen_s or timeout_seen_s)
    else $error("proc enable changed off schedule");
  spread_apply_a: assert property (
    $changed(sataSpreadOn) |-> done_seen_s)
    else $error("spread changed off schedule");
  div_hold_a: assert property (
    $changed(procM) |-> done_seen_s or timeout_seen_s)
    else $error("proc divider changed off schedule");
  pcie_direct_a: assert property (
    $changed(pcieN) && !glideToPcie && !$past(glideToPcie) |-> done_seen_s)
    else $error("pcie N changed off schedule");
  owner_apply_a: assert property (
    $changed(glideToPcie) |-> done_seen_s)
    else $error("glide owner changed off schedule");
  ramp_step_a: assert property (
    glideBusy && $past(glideBusy) && !glideToPcie && $stable(glideToPcie)
      && procProgActive && $past(procProgActive) && $changed(procN)
      |-> procN == $past(procN) + 9'h001 || procN == $past(procN) - 9'h001)
    else $error("ramp moved more than one code");
  strap_clear_a: assert property (
    strap_timeout_s |-> ##3 !procProgActive)
    else $error("strap recovery kept proc enable");
endmodule
bind ofp_freq_control ofp_freq_properties #(.STEP_CYCLES(STEP_CYCLES)) uProps (
  .sys_clk, .rst, .writeDone, .watchdogEnable, .watchdogTimeout, .procN,
  .procM, .procProgActive, .pcieN, .pcieM, .sataSpreadOn, .refClkBOutEn,
  .fsSerialClkOutEn, .glideToPcie, .glideBusy, .recoveryAction);
`default_nettype wire

// ---- sim/ofp_host_model.sv ----
// Purpose: serial host side model issuing byte writes and reads
// Assumes: callers enter tasks 1 ns after a rising edge
// Notes: released index and data lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module ofp_host_model (
  // Clock
  input wire sys_clk,
  // Register port
  output logic regWrite,
  output logic [7:0] regIndex,
  output logic [7:0] regWrData,
  output logic writeDone,
  input wire [7:0] regRdData
);
  // Idle port at time zero
  initial begin
    regWrite = 1'b0;
    regIndex = 8'h00;
    regWrData = 8'h00;
    writeDone = 1'b0;
  end
  // One byte; strobe stays up for a following byte
  task wr(input logic [7:0] i, input logic [7:0] d);
    regWrite = 1'b1;
    regIndex = i;
    regWrData = d;
    @(posedge sys_clk);
    #1;
  endtask
  // Stop condition; old index and data no longer held
  task done();
    regWrite = 1'b0;
    writeDone = 1'b1;
    regIndex = ~regIndex;
    regWrData = ~regWrData;
    @(posedge sys_clk);
    #1;
    writeDone = 1'b0;
  endtask
  // Readback arrives one edge after the index
  task rd(input logic [7:0] i, output logic [7:0] d);
    regIndex = i;
    @(posedge sys_clk);
    #1;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the frequency program control block
// Assumes: ramp step shortened to 2 cycles
// Notes: every scenario task judges its own results
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic strapLatch = 1'b0;
  logic [4:0] ratePins = 5'h00;
  logic watchdogEnable = 1'b0;
  logic watchdogTimeout = 1'b0;
  wire regWrite, writeDone, procProgActive, pcieProgActive, sataSpreadOn;
  wire refClkBOutEn, fsSerialClkOutEn, glideToPcie, glideBusy;
  wire [7:0] regIndex, regWrData, regRdData;
  wire [8:0] procN, pcieN;
  wire [6:0] procM, pcieM;
  wire [4:0] procGearCode;
  wire [1:0] pcieRateSel, recoveryAction;
  logic [7:0] rb;
  logic [7:0] md [4] = '{8'h02, 8'h00, 8'h01, 8'h01};
  logic [7:0] en [4] = '{8'hC6, 8'hC6, 8'hC6, 8'hC7};
  logic [15:0] ra [4] = '{16'h0000, 16'h0003, 16'h0002, 16'h0001};
  int mismatches = 0;
  int n_tests = 0;
  // ==========================================
  // Clock, host model and design
  always #10 sys_clk = ~sys_clk;
  ofp_host_model host (.sys_clk, .regWrite, .regIndex, .regWrData,
    .writeDone, .regRdData);
  ofp_freq_control #(.STEP_CYCLES(2)) dut (.sys_clk, .rst, .clkEn,
    .regWrite, .regIndex, .regWrData, .writeDone, .regRdData, .strapLatch,
    .ratePins, .watchdogEnable, .watchdogTimeout, .procN, .procM,
    .procGearCode, .procProgActive, .pcieN, .pcieM, .pcieRateSel,
    .pcieProgActive, .sataSpreadOn, .refClkBOutEn, .fsSerialClkOutEn,
    .glideToPcie, .glideBusy, .recoveryAction);
  // ==========================================
  // Shared helpers
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %0t: %s got %h exp %h", $time, s, got, exp);
      mismatches++;
    end
  endtask
  task apply(input logic [7:0] i, input logic [7:0] d);
    host.wr(i, d);
    host.done();
    tick(2);
  endtask
  task latch(input logic [4:0] p);
    ratePins = p;
    strapLatch = 1'b1;
    tick(1);
    strapLatch = 1'b0;
  endtask
  // ==========================================
  // Scenarios
  task t_reset();
    chk(pcieM, 16'h000F, "pcie divider");
    chk({procN, procM}, 16'h0000, "proc N M");
    host.rd(8'h10, rb);
    chk(rb, 16'h00C0, "enables");
    host.rd(8'h0F, rb);
    chk(rb, 16'h0000, "restore low");
    $display("reset test done");
  endtask
  task t_enables();
    apply(8'h10, 8'h08);
    chk({refClkBOutEn, fsSerialClkOutEn, sataSpreadOn}, 16'h1, "spread");
    apply(8'h10, 8'hD8);
    host.rd(8'h10, rb);
    chk(rb, 16'h00C8, "reserved bit");
    latch(5'h10);
    apply(8'h10, 8'hC8);
    chk(pcieRateSel, 16'h0001, "strap rate");
    apply(8'h10, 8'hE8);
    chk(pcieRateSel, 16'h0002, "fixed high rate");
    latch(5'h03);
    apply(8'h10, 8'hC8);
    chk(pcieRateSel, 16'h0000, "base rate");
    chk(procGearCode, 16'h0003, "strap gear");
    host.wr(8'h11, 8'h0A);
    apply(8'h0E, 8'h20);
    chk(procGearCode[3:0], 16'h000A, "soft gear");
    apply(8'h0E, 8'h00);
    $display("enables test done");
  endtask
  task t_proc();
    host.wr(8'h0B, 8'h06);
    apply(8'h0C, 8'h83);
    apply(8'h10, 8'hC2);
    tick(600);
    chk(procProgActive, 16'h0001, "proc prog on");
    chk({procN, procM}, {9'h106, 7'h03}, "proc N M");
    host.wr(8'h0B, 8'h04);
    tick(4);
    chk(procN, 16'h0106, "before stop");
    host.done();
    tick(20);
    chk({procN, procM}, {9'h104, 7'h03}, "N only");
    $display("proc test done");
  endtask
  task t_pcie();
    host.wr(8'h0D, 8'h21);
    apply(8'h0E, 8'h80);
    apply(8'h10, 8'hC6);
    chk({pcieProgActive, pcieN}, 16'h0321, "pcie prog");
    apply(8'h0E, 8'h90);
    chk(glideToPcie, 16'h0001, "owner pcie");
    apply(8'h0D, 8'h25);
    chk(glideBusy, 16'h0001, "ramp busy");
    tick(20);
    chk(pcieN, 16'h0125, "ramp end");
    apply(8'h0E, 8'h80);
    $display("pcie test done");
  endtask
  task t_recover();
    host.wr(8'h0E, 8'h81);
    apply(8'h0F, 8'h34);
    host.rd(8'h0F, rb);
    chk(rb, 16'h0034, "restore low");
    host.rd(8'h0E, rb);
    chk(rb[0], 16'h0001, "restore top bit");
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h12, md[k]);
      apply(8'h10, en[k]);
      chk(recoveryAction, ra[k], "recovery action");
    end
    apply(8'h0F, 8'h55);
    host.rd(8'h0F, rb);
    chk(rb, 16'h0034, "refused restore");
    host.wr(8'h12, 8'h01);
    apply(8'h10, 8'hC4);
    chk(recoveryAction, 16'h0002, "manual selected");
    watchdogTimeout = 1'b1;
    tick(1);
    watchdogTimeout = 1'b0;
    tick(3);
    chk({pcieProgActive, pcieN}, 16'h0325, "pcie only");
    host.wr(8'h12, 8'h00);
    apply(8'h10, 8'hC6);
    watchdogEnable = 1'b1;
    tick(2);
    watchdogTimeout = 1'b1;
    tick(1);
    watchdogTimeout = 1'b0;
    tick(2);
    chk({procProgActive, pcieN}, 16'h0125, "strap restore");
    host.rd(8'h10, rb);
    chk(rb, 16'h00C4, "enable cleared");
    $display("recovery test done");
  endtask
  task t_freeze();
    clkEn = 1'b0;
    apply(8'h10, 8'hC0);
    clkEn = 1'b1;
    host.rd(8'h10, rb);
    chk(rb, 16'h00C4, "frozen write");
    $display("freeze test done");
  endtask
  // ==========================================
  // Verdict, main sequence and watchdog
  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_enables();
    t_proc();
    t_pcie();
    t_recover();
    t_freeze();
    give_verdict();
  end
  initial begin
    #100000;
    $display("ERROR %0t: run did not finish", $time);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
